// ===== rtl/ledft_core.sv
// Flash/torch control core: registers, sequencing, ramp, split, sync override, monitor
// Operation
// - Flash offers 128 levels, zero to 1500 mA
// - Flash ceiling bits 3:0, flash level 6:0
// - Flash starts by mode bits or strobe rise
// - Flash current steps through every code
// - Second source gets flash ceiling minus first
// - First over ceiling: clamp it, second off
// - Flash completion clears mode bits; host resets
// - Torch offers 128 levels, zero to 187.5 mA
// - Torch ceiling bits 6:4, torch level 6:0
// - Torch starts by register or pin, ramps
// - Second source gets torch ceiling minus first
// - First over torch ceiling: clamp, second off
// - Flash timeout never affects torch
// - Sources off during precharge, then ramp up
// - Start in pass, boost on low headroom
// - Sync high during flash forces torch level
// - Sync low restores previous flash level
// - Timeout turns current off regardless of sync
// - Sync enable bit zero ignores sync input
// - Monitor threshold bits 4:3, hysteresis 2:1
// - Down crossing sets flag bit 3
// - Stop-and-hold freezes ramp on crossing
// - Down-only lowers, never raises until next flash
// - Up-and-down lowers and raises continually
// - Timeout bits 2:0, 50 to 400 ms
// - Timeout clears mode bits, sets flag 0
`timescale 1ns/1ps
`default_nettype none
module ledft_core import ledft_pkg::*; #(
	parameter int unsigned TMO_STEP_CYCLES = TMO_STEP_CYCLES_DEF,
	parameter int unsigned STEP_CYCLES = RAMP_STEP_CYCLES_DEF
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Register port from the serial interface
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	// Asynchronous pins and analog indications
	input wire ledft_pins_s pinsIn,
	input wire ledft_ana_s anaIn,
	input wire logic [1:0] monitorMode,
	// Current source controls
	output logic [LVL_W-1:0] firstCode,
	output logic [LVL_W-1:0] secondCode,
	output logic firstOn,
	output logic secondOn,
	// Converter and monitor controls
	output logic prechargeOn,
	output logic boostOn,
	output logic [1:0] monThreshSel,
	output logic [1:0] monHystSel
);
	localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);

	function automatic logic [LVL_W-1:0] stepLevel(input logic [LVL_W-1:0] cur, input logic [LVL_W-1:0] tgt,
		input logic up, input logic down);
		if (down && cur != '0) begin
			stepLevel = cur - 7'h1;
		end else if (up && cur < tgt) begin
			stepLevel = cur + 7'h1;
		end else if (cur > tgt) begin
			stepLevel = cur - 7'h1;
		end else begin
			stepLevel = cur;
		end
	endfunction : stepLevel

	ledft_pins_s pinsS;
	ledft_ana_s anaS;
	ledft_state_e stateQ;
	ledft_state_e stateD;
	logic [7:0] modeQ, monCfgQ, timingQ, ceilQ, flashLvlQ, torchLvlQ, flagsQ;
	logic [7:0] modeD, flagsD, rdMux, rdDataQ;
	logic strobePrevQ, torchPrevQ, belowPrevQ;
	logic isFlashQ, extQ, holdQ, decQ, downSeenQ, boostQ;
	logic [15:0] stepCntQ;
	logic [31:0] tmoCntQ, tmoLimit;
	logic [LVL_W-1:0] curQ [2];
	logic [LVL_W-1:0] curD [2];
	logic [LVL_W-1:0] tgt [2];
	logic [LVL_W-1:0] flashTgt [2];
	logic [LVL_W-1:0] torchTgt [2];
	logic [LVL_W-1:0] flashCeil, torchCeil;
	logic [LVL_W-1:0] firstCodeQ, secondCodeQ;
	logic firstOnQ, secondOnQ, prechargeQ;
	logic flashSecondEn, torchSecondEn;
	logic m0, m1, strobeRise, torchRise, belowRise;
	logic intFlashReq, extFlashReq, intTorchReq, extTorchReq, startReq, startFlash;
	logic endReq, tmoHit, flashDone, txAct, useTorchOut, stepTick, rampFreeze, ramping;
	logic monHold, monDown, monUpDn, allowUp, forceDown;
	logic modeWr, flagsRd, tmoSet, monSet;

	ledft_sync #(.WIDTH($bits(ledft_pins_s))) uPinSync (
		.sys_clk(sys_clk),
		.srst(srst),
		.asyncIn(pinsIn),
		.syncOut(pinsS)
	);

	ledft_sync #(.WIDTH($bits(ledft_ana_s))) uAnaSync (
		.sys_clk(sys_clk),
		.srst(srst),
		.asyncIn(anaIn),
		.syncOut(anaS)
	);

	// Ceiling code fills the top bits so full scale reaches code 127
	assign flashCeil = {ceilQ[CEIL_FLASH_LSB +: 4], FLASH_CEIL_FILL};
	assign torchCeil = {ceilQ[CEIL_TORCH_LSB +: 3], TORCH_CEIL_FILL};

	ledft_split uFlashSplit (
		.ceilCode(flashCeil),
		.level(flashLvlQ[LVL_W-1:0]),
		.firstTgt(flashTgt[0]),
		.secondTgt(flashTgt[1]),
		.secondEn(flashSecondEn)
	);

	ledft_split uTorchSplit (
		.ceilCode(torchCeil),
		.level(torchLvlQ[LVL_W-1:0]),
		.firstTgt(torchTgt[0]),
		.secondTgt(torchTgt[1]),
		.secondEn(torchSecondEn)
	);

	// Start decoding
	assign m0 = modeQ[MODE_M0_BIT];
	assign m1 = modeQ[MODE_M1_BIT];
	assign strobeRise = pinsS.strobe & ~strobePrevQ;
	assign torchRise = pinsS.torch & ~torchPrevQ;
	assign belowRise = anaS.monBelow & ~belowPrevQ;
	assign intFlashReq = m1 & m0 & ~modeQ[MODE_STROBE_EN_BIT];
	assign extFlashReq = m1 & m0 & modeQ[MODE_STROBE_EN_BIT] & strobeRise;
	assign intTorchReq = m1 & ~m0;
	assign extTorchReq = ~m1 & modeQ[MODE_TORCH_EN_BIT] & torchRise;
	assign startFlash = intFlashReq | extFlashReq;
	assign startReq = startFlash | intTorchReq | extTorchReq;

	// Stop decoding; a pin-started event ends with its pin
	assign endReq = isFlashQ ? (~(m1 & m0) | (extQ & ~pinsS.strobe))
		: (extQ ? ~pinsS.torch : ~(m1 & ~m0));

	// Timeout counts only during flash
	assign tmoLimit = 32'((32'(timingQ[TMO_SEL_LSB +: 3]) + 32'h1) * TMO_STEP_CYCLES);
	assign tmoHit = isFlashQ & (stateQ == ST_ON) & (tmoCntQ == tmoLimit - 32'h1);
	assign flashDone = isFlashQ & (stateQ != ST_OFF) & (endReq | tmoHit);

	// Sync override
	assign txAct = pinsS.tx & modeQ[MODE_TX_EN_BIT] & isFlashQ & (stateQ == ST_ON);
	assign useTorchOut = ~isFlashQ | txAct;

	// Monitor mode decode
	assign monHold = monitorMode == MON_HOLD;
	assign monDown = monitorMode == MON_DOWN;
	assign monUpDn = monitorMode == MON_UPDN;
	assign monThreshSel = monCfgQ[MON_THR_LSB +: 2];
	assign monHystSel = monCfgQ[MON_HYS_LSB +: 2];
	assign allowUp = ~isFlashQ | (monUpDn ? ~decQ : (monDown ? ~downSeenQ : 1'b1));
	assign forceDown = isFlashQ & decQ & (monDown | monUpDn);

	// Ramp pacing; the flash ramp is frozen, not rewound, while overridden
	assign stepTick = (stateQ == ST_ON) & (stepCntQ == STEP_LAST);
	assign rampFreeze = txAct | holdQ;
	assign ramping = (curQ[0] != tgt[0]) | (curQ[1] != tgt[1]);

	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_src
			assign tgt[i] = isFlashQ ? flashTgt[i] : torchTgt[i];
			assign curD[i] = (stateQ != ST_ON) ? '0
				: ((stepTick & ~rampFreeze) ? stepLevel(curQ[i], tgt[i], allowUp, forceDown) : curQ[i]);
		end
	endgenerate

	// Sequencer
	always_comb begin
		stateD = stateQ;
		case (stateQ)
			ST_OFF: begin
				if (startReq) begin
					stateD = ST_PRECHG;
				end
			end
			ST_PRECHG: begin
				if (endReq) begin
					stateD = ST_OFF;
				end else if (anaS.outReady) begin
					stateD = ST_ON;
				end
			end
			ST_ON: begin
				if (endReq | tmoHit) begin
					stateD = ST_OFF;
				end
			end
			default: begin
				stateD = ST_OFF;
			end
		endcase
	end

	// Register access
	assign modeWr = regWrEn & (regAddr == ADDR_MODE);
	assign flagsRd = regRdEn & (regAddr == ADDR_FLAGS);
	assign modeD = modeWr ? regWrData : (flashDone ? {modeQ[7:2], 2'h0} : modeQ);
	assign tmoSet = tmoHit;
	assign monSet = belowRise;
	// Event set wins over read-to-clear
	assign flagsD = (flagsRd ? FLAGS_RST : flagsQ) | (8'(tmoSet) << FLAG_TMO_BIT)
		| (8'(monSet) << FLAG_MON_BIT);
	assign rdMux = (regAddr == ADDR_MODE) ? modeQ
		: (regAddr == ADDR_MONCFG) ? monCfgQ
		: (regAddr == ADDR_TIMING) ? timingQ
		: (regAddr == ADDR_CEIL) ? ceilQ
		: (regAddr == ADDR_FLASH_LVL) ? flashLvlQ
		: (regAddr == ADDR_TORCH_LVL) ? torchLvlQ
		: (regAddr == ADDR_FLAGS) ? flagsQ : 8'h00;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			modeQ <= MODE_RST;
			monCfgQ <= MONCFG_RST;
			timingQ <= TIMING_RST;
			ceilQ <= CEIL_RST;
			flashLvlQ <= LVL_RST;
			torchLvlQ <= LVL_RST;
			flagsQ <= FLAGS_RST;
			rdDataQ <= 8'h00;
		end else begin
			modeQ <= modeD;
			flagsQ <= flagsD;
			monCfgQ <= (regWrEn && regAddr == ADDR_MONCFG) ? regWrData : monCfgQ;
			timingQ <= (regWrEn && regAddr == ADDR_TIMING) ? regWrData : timingQ;
			ceilQ <= (regWrEn && regAddr == ADDR_CEIL) ? regWrData : ceilQ;
			flashLvlQ <= (regWrEn && regAddr == ADDR_FLASH_LVL) ? regWrData : flashLvlQ;
			torchLvlQ <= (regWrEn && regAddr == ADDR_TORCH_LVL) ? regWrData : torchLvlQ;
			rdDataQ <= regRdEn ? rdMux : rdDataQ;
		end
	end

	// Sequencer, counters and monitor state
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			stateQ <= ST_OFF;
			isFlashQ <= 1'b0;
			extQ <= 1'b0;
			strobePrevQ <= 1'b0;
			torchPrevQ <= 1'b0;
			belowPrevQ <= 1'b0;
			stepCntQ <= 16'h0000;
			tmoCntQ <= 32'h0;
			curQ[0] <= '0;
			curQ[1] <= '0;
		end else begin
			stateQ <= stateD;
			strobePrevQ <= pinsS.strobe;
			torchPrevQ <= pinsS.torch;
			belowPrevQ <= anaS.monBelow;
			if (stateQ == ST_OFF && startReq) begin
				isFlashQ <= startFlash;
				extQ <= startFlash ? extFlashReq : extTorchReq;
			end
			stepCntQ <= (stateQ != ST_ON || stepTick) ? 16'h0000 : stepCntQ + 16'h0001;
			tmoCntQ <= (isFlashQ && stateQ == ST_ON) ? tmoCntQ + 32'h1 : 32'h0;
			curQ[0] <= curD[0];
			curQ[1] <= curD[1];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			holdQ <= 1'b0;
			decQ <= 1'b0;
			downSeenQ <= 1'b0;
		end else if (stateQ != ST_ON || !isFlashQ) begin
			holdQ <= 1'b0;
			decQ <= 1'b0;
			downSeenQ <= 1'b0;
		end else begin
			holdQ <= holdQ | (monHold & anaS.monBelow & ramping);
			decQ <= (monDown | monUpDn) & (anaS.monBelow | (decQ & ~anaS.monAboveHyst));
			downSeenQ <= downSeenQ | (monDown & anaS.monBelow);
		end
	end

	// Outputs follow the next state so a stop shows on the same edge
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			firstCodeQ <= '0;
			secondCodeQ <= '0;
			firstOnQ <= 1'b0;
			secondOnQ <= 1'b0;
			prechargeQ <= 1'b0;
			boostQ <= 1'b0;
		end else begin
			firstCodeQ <= (stateD == ST_ON) ? (txAct ? torchTgt[0] : curD[0]) : '0;
			secondCodeQ <= (stateD == ST_ON) ? (txAct ? torchTgt[1] : curD[1]) : '0;
			firstOnQ <= stateD == ST_ON;
			secondOnQ <= (stateD == ST_ON) & (useTorchOut ? torchSecondEn : flashSecondEn);
			prechargeQ <= stateD == ST_PRECHG;
			boostQ <= (stateD == ST_OFF) ? 1'b0 : (boostQ | ((stateQ == ST_ON) & anaS.lowHeadroom));
		end
	end

	assign regRdData = rdDataQ;
	assign firstCode = firstCodeQ;
	assign secondCode = secondCodeQ;
	assign firstOn = firstOnQ;
	assign secondOn = secondOnQ;
	assign prechargeOn = prechargeQ;
	assign boostOn = boostQ;

	// Checks
	logic [LVL_W-1:0] cur0;
	assign cur0 = curQ[0];

	property p_tmo_clear;
		@(posedge sys_clk) disable iff (srst) tmoHit && !modeWr |=> modeQ[1:0] == 2'h0 && flagsQ[FLAG_TMO_BIT];
	endproperty
	a_tmo_clear: assert property (p_tmo_clear) else $error("timeout did not clear mode or set flag");

	property p_tmo_off;
		@(posedge sys_clk) disable iff (srst) tmoHit |=> firstCode == '0 && !firstOn && !secondOn;
	endproperty
	a_tmo_off: assert property (p_tmo_off) else $error("current left on after timeout");

	property p_flash_sum;
		@(posedge sys_clk) disable iff (srst) flashSecondEn |-> 7'(flashTgt[0] + flashTgt[1]) == flashCeil;
	endproperty
	a_flash_sum: assert property (p_flash_sum) else $error("flash split does not sum to ceiling");

	property p_flash_over;
		@(posedge sys_clk) disable iff (srst)
			flashLvlQ[6:0] > flashCeil |-> flashTgt[0] == flashCeil && !flashSecondEn;
	endproperty
	a_flash_over: assert property (p_flash_over) else $error("flash over ceiling not clamped");

	property p_torch_over;
		@(posedge sys_clk) disable iff (srst)
			torchLvlQ[6:0] > torchCeil |-> torchTgt[0] == torchCeil && !torchSecondEn;
	endproperty
	a_torch_over: assert property (p_torch_over) else $error("torch over ceiling not clamped");

	property p_ramp_step;
		@(posedge sys_clk) disable iff (srst) stateQ == ST_ON && $past(stateQ) == ST_ON |->
			cur0 == $past(cur0) || cur0 == 7'($past(cur0) + 7'h1) || 7'(cur0 + 7'h1) == $past(cur0);
	endproperty
	a_ramp_step: assert property (p_ramp_step) else $error("ramp skipped a code");

	property p_prechg_off;
		@(posedge sys_clk) disable iff (srst) stateQ == ST_PRECHG |-> !firstOn && !secondOn && prechargeOn;
	endproperty
	a_prechg_off: assert property (p_prechg_off) else $error("source on during precharge");

	property p_torch_no_tmo;
		@(posedge sys_clk) disable iff (srst) !isFlashQ |-> !tmoHit && tmoCntQ == 32'h0;
	endproperty
	a_torch_no_tmo: assert property (p_torch_no_tmo) else $error("timeout active in torch");

	property p_mon_flag;
		@(posedge sys_clk) disable iff (srst) belowRise |=> flagsQ[FLAG_MON_BIT];
	endproperty
	a_mon_flag: assert property (p_mon_flag) else $error("monitor flag not set");

	property p_tx_ignore;
		@(posedge sys_clk) disable iff (srst) !modeQ[MODE_TX_EN_BIT] |-> !txAct;
	endproperty
	a_tx_ignore: assert property (p_tx_ignore) else $error("sync acted while disabled");

	property p_tx_level;
		@(posedge sys_clk) disable iff (srst) txAct && stateD == ST_ON |=> firstCode == $past(torchTgt[0]);
	endproperty
	a_tx_level: assert property (p_tx_level) else $error("override not at torch level");

	property p_pass_start;
		@(posedge sys_clk) disable iff (srst) stateQ == ST_OFF |-> !boostOn;
	endproperty
	a_pass_start: assert property (p_pass_start) else $error("boost while off");

	property p_hold;
		@(posedge sys_clk) disable iff (srst) holdQ && $past(holdQ) |-> $stable(cur0);
	endproperty
	a_hold: assert property (p_hold) else $error("ramp moved while held");

	c_flash_tmo: cover property (@(posedge sys_clk) disable iff (srst) tmoHit);
	c_tx: cover property (@(posedge sys_clk) disable iff (srst) txAct ##1 !txAct && stateQ == ST_ON);
	c_torch: cover property (@(posedge sys_clk) disable iff (srst) stateQ == ST_ON && !isFlashQ);
	c_mon: cover property (@(posedge sys_clk) disable iff (srst) belowRise && isFlashQ);
endmodule : ledft_core
`default_nettype wire

// ===== rtl/ledft_pkg.sv
// Constants, carriers and state types shared by the flash/torch control block
package ledft_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_MODE = 8'h01;
	localparam logic [7:0] ADDR_MONCFG = 8'h02;
	localparam logic [7:0] ADDR_TIMING = 8'h04;
	localparam logic [7:0] ADDR_CEIL = 8'h05;
	localparam logic [7:0] ADDR_FLASH_LVL = 8'h06;
	localparam logic [7:0] ADDR_TORCH_LVL = 8'h07;
	localparam logic [7:0] ADDR_FLAGS = 8'h08;
	// Reset values
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] MONCFG_RST = 8'h00;
	localparam logic [7:0] TIMING_RST = 8'h00;
	localparam logic [7:0] CEIL_RST = 8'h00;
	localparam logic [7:0] LVL_RST = 8'h00;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	// Field positions
	localparam int unsigned MODE_M0_BIT = 0;
	localparam int unsigned MODE_M1_BIT = 1;
	localparam int unsigned MODE_STROBE_EN_BIT = 2;
	localparam int unsigned MODE_TORCH_EN_BIT = 3;
	localparam int unsigned MODE_TX_EN_BIT = 4;
	localparam int unsigned CEIL_FLASH_LSB = 0;
	localparam int unsigned CEIL_TORCH_LSB = 4;
	localparam int unsigned MON_THR_LSB = 3;
	localparam int unsigned MON_HYS_LSB = 1;
	localparam int unsigned TMO_SEL_LSB = 0;
	localparam int unsigned FLAG_TMO_BIT = 0;
	localparam int unsigned FLAG_MON_BIT = 3;
	// Level code width and ceiling fill bits (ceiling code sits in the top bits)
	localparam int unsigned LVL_W = 7;
	localparam logic [2:0] FLASH_CEIL_FILL = 3'h7;
	localparam logic [3:0] TORCH_CEIL_FILL = 4'hf;
	// Timing
	localparam longint unsigned CLK_HZ = 50000000;
	localparam longint unsigned TMO_STEP_MS = 50;
	localparam int unsigned TMO_STEP_CYCLES_DEF = int'(CLK_HZ / 1000 * TMO_STEP_MS);
	localparam int unsigned RAMP_STEP_CYCLES_DEF = 16;
	// Monitor mode encodings
	localparam logic [1:0] MON_OFF = 2'h0;
	localparam logic [1:0] MON_HOLD = 2'h1;
	localparam logic [1:0] MON_DOWN = 2'h2;
	localparam logic [1:0] MON_UPDN = 2'h3;

	typedef struct packed {
		logic strobe;
		logic torch;
		logic tx;
	} ledft_pins_s;

	typedef struct packed {
		logic outReady;
		logic lowHeadroom;
		logic monBelow;
		logic monAboveHyst;
	} ledft_ana_s;

	typedef enum logic [1:0] {ST_OFF, ST_PRECHG, ST_ON} ledft_state_e;
endpackage : ledft_pkg

// ===== rtl/ledft_sync.sv
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module ledft_sync import ledft_pkg::*; #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Levels
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta_q;
			logic sync_q;
			always_ff @(posedge sys_clk) begin
				if (srst) begin
					meta_q <= 1'b0;
					sync_q <= 1'b0;
				end else begin
					meta_q <= asyncIn[i];
					sync_q <= meta_q;
				end
			end
			assign syncOut[i] = sync_q;
		end
	endgenerate
endmodule : ledft_sync
`default_nettype wire

// ===== rtl/ledft_split.sv
// Splits a ceiling between the first and second current sources
`timescale 1ns/1ps
`default_nettype none
module ledft_split import ledft_pkg::*; (
	// Settings
	input wire logic [LVL_W-1:0] ceilCode,
	input wire logic [LVL_W-1:0] level,
	// Targets
	output logic [LVL_W-1:0] firstTgt,
	output logic [LVL_W-1:0] secondTgt,
	output logic secondEn
);
	logic over;
	assign over = level > ceilCode;
	assign firstTgt = over ? ceilCode : level;
	assign secondTgt = over ? '0 : ceilCode - level;
	assign secondEn = ~over;
endmodule : ledft_split
`default_nettype wire

// ===== tb/ledft_host.sv
// Host-side register master model for the flash/torch control block
`timescale 1ns/1ps
`default_nettype none
module ledft_host (
	// Clock
	input wire logic sys_clk,
	// Register port
	output logic regWrEn,
	output logic regRdEn,
	output logic [7:0] regAddr,
	output logic [7:0] regWrData,
	input wire logic [7:0] regRdData
);
	initial begin
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regAddr = 8'h00;
		regWrData = 8'h00;
	end

	// Callers rewrite the mode bits before every new enable
	task automatic wrReg(input logic [7:0] addr, input logic [7:0] data);
		@(posedge sys_clk);
		#1;
		regWrEn = 1'b1;
		regAddr = addr;
		regWrData = data;
		@(posedge sys_clk);
		#1;
		regWrEn = 1'b0;
		// Released lines flip so a stale value never passes for a live one
		regAddr = ~addr;
		regWrData = ~data;
	endtask : wrReg

	task automatic rdReg(input logic [7:0] addr, output logic [7:0] data);
		@(posedge sys_clk);
		#1;
		regRdEn = 1'b1;
		regAddr = addr;
		@(posedge sys_clk);
		#1;
		data = regRdData;
		regRdEn = 1'b0;
		regAddr = ~addr;
	endtask : rdReg
endmodule : ledft_host
`default_nettype wire

// ===== tb/led_flash_torch_control_bench.sv
// Self-checking bench for the flash/torch control block
`timescale 1ns/1ps
`default_nettype none
module led_flash_torch_control_bench;
	import ledft_pkg::*;
	logic sys_clk, srst, regWrEn, regRdEn, rampChk;
	logic [7:0] regAddr, regWrData, regRdData;
	ledft_pins_s pinsIn;
	ledft_ana_s anaIn;
	logic [1:0] monitorMode, monThreshSel, monHystSel;
	logic [LVL_W-1:0] firstCode, secondCode, prevCode, tgt;
	logic firstOn, secondOn, prechargeOn, boostOn;
	logic [4:0] cond;
	int badCount = 0;
	int cmpCount = 0;
	logic [7:0] wa [5] = '{ADDR_TIMING, ADDR_CEIL, ADDR_FLASH_LVL, ADDR_TORCH_LVL, ADDR_MONCFG};
	logic [7:0] wv [5] = '{8'h07, 8'h25, 8'h10, 8'h05, 8'h1a};

	// Wait conditions: 4 precharge, 3 on, 2 off, 1 at target, 0 boost
	assign cond = {prechargeOn, firstOn, ~firstOn, firstCode == tgt, boostOn};

	ledft_host host (.sys_clk(sys_clk), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
		.regWrData(regWrData), .regRdData(regRdData));

	ledft_core #(.TMO_STEP_CYCLES(20), .STEP_CYCLES(2)) dut (.sys_clk(sys_clk), .srst(srst),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
		.regRdData(regRdData), .pinsIn(pinsIn), .anaIn(anaIn), .monitorMode(monitorMode),
		.firstCode(firstCode), .secondCode(secondCode), .firstOn(firstOn), .secondOn(secondOn),
		.prechargeOn(prechargeOn), .boostOn(boostOn), .monThreshSel(monThreshSel),
		.monHystSel(monHystSel));

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task automatic completeRun();
		$display("Comparisons %0d, mismatches %0d", cmpCount, badCount);
		if (badCount == 0 && cmpCount > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : completeRun

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		cmpCount++;
		if (seen !== exp) begin
			badCount++;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic tick(input int c);
		repeat (c) @(posedge sys_clk);
		#1;
	endtask : tick

	task automatic waitCond(input int idx, input int lim, output int n);
		n = 0;
		while (cond[idx] !== 1'b1 && n < lim) begin
			tick(1);
			n++;
		end
		if (cond[idx] !== 1'b1) begin
			badCount++;
			$display("MISMATCH at %0t: wait %0d ran out", $time, idx);
			completeRun();
		end
	endtask : waitCond

	// Ramp may move only one code up at a time while watched
	always @(posedge sys_clk) begin
		if (rampChk === 1'b1 && firstCode !== prevCode) begin
			check({1'b0, firstCode}, {1'b0, prevCode} + 8'h01, "ramp step");
		end
		prevCode <= firstCode;
	end

	initial begin
		logic [7:0] rd;
		int n;
		srst = 1'b1;
		pinsIn = '0;
		anaIn = '0;
		monitorMode = MON_OFF;
		rampChk = 1'b0;
		tgt = '0;
		repeat (3) @(posedge sys_clk);
		#1;
		srst = 1'b0;
		for (n = 1; n < 9; n++) begin
			host.rdReg(8'(n), rd);
			check(rd, 8'h00, "reset value");
		end
		for (n = 0; n < 5; n++) host.wrReg(wa[n], wv[n]);
		host.wrReg(8'h03, 8'hff);
		for (n = 0; n < 5; n++) begin
			host.rdReg(wa[n], rd);
			check(rd, wv[n], "readback");
		end
		host.rdReg(8'h03, rd);
		check(rd, 8'h00, "unmapped");
		check({6'h00, monThreshSel}, 8'h03, "threshold");
		check({6'h00, monHystSel}, 8'h01, "hysteresis");
		// Internal flash with output held unready for a while
		tgt = 7'd16;
		host.wrReg(ADDR_MODE, 8'h03);
		waitCond(4, 10, n);
		tick(5);
		check({7'h00, firstOn}, 8'h00, "source in precharge");
		check({7'h00, boostOn}, 8'h00, "pass at start");
		anaIn.outReady = 1'b1;
		rampChk = 1'b1;
		waitCond(1, 100, n);
		tick(40);
		rampChk = 1'b0;
		check({1'b0, firstCode}, 8'd16, "first flash");
		check({1'b0, secondCode}, 8'd31, "second flash");
		check({7'h00, secondOn}, 8'h01, "second on");
		anaIn.lowHeadroom = 1'b1;
		waitCond(0, 10, n);
		anaIn.lowHeadroom = 1'b0;
		waitCond(2, 200, n);
		check({firstCode, secondOn}, 8'h00, "off after timeout");
		host.rdReg(ADDR_MODE, rd);
		check(rd, 8'h00, "mode cleared");
		host.rdReg(ADDR_FLAGS, rd);
		check(rd, 8'h01, "timeout flag");
		host.rdReg(ADDR_FLAGS, rd);
		check(rd, 8'h00, "flags read clear");
		// Internal torch outlives the flash timeout
		tgt = 7'd5;
		host.wrReg(ADDR_MODE, 8'h02);
		waitCond(1, 100, n);
		tick(200);
		check({firstOn, firstCode}, 8'h85, "torch first");
		check({secondOn, secondCode}, 8'haa, "torch second");
		host.rdReg(ADDR_MODE, rd);
		check(rd, 8'h02, "torch keeps mode");
		host.wrReg(ADDR_MODE, 8'h00);
		waitCond(2, 10, n);
		// Torch pin with level above its ceiling
		tgt = 7'd47;
		host.wrReg(ADDR_TORCH_LVL, 8'h7f);
		host.wrReg(ADDR_MODE, 8'h08);
		pinsIn.torch = 1'b1;
		waitCond(1, 200, n);
		tick(3);
		check({secondOn, firstCode}, 8'h2f, "torch clamp");
		pinsIn.torch = 1'b0;
		waitCond(2, 10, n);
		// Strobe flash clamped, with sync override
		host.wrReg(ADDR_TORCH_LVL, 8'h05);
		host.wrReg(ADDR_FLASH_LVL, 8'h40);
		host.wrReg(ADDR_MODE, 8'h17);
		pinsIn.strobe = 1'b1;
		waitCond(1, 200, n);
		check({secondOn, firstCode}, 8'h2f, "flash clamp");
		pinsIn.tx = 1'b1;
		tick(5);
		check({firstCode, secondOn}, 8'h0b, "tx torch first");
		check({1'b0, secondCode}, 8'd42, "tx torch second");
		pinsIn.tx = 1'b0;
		tick(5);
		check({secondOn, firstCode}, 8'h2f, "tx released");
		pinsIn.tx = 1'b1;
		waitCond(2, 200, n);
		check({1'b0, firstCode}, 8'h00, "off with tx high");
		host.rdReg(ADDR_MODE, rd);
		check(rd, 8'h14, "pin flash clears mode");
		host.rdReg(ADDR_FLAGS, rd);
		check(rd, 8'h01, "pin flash timeout");
		pinsIn.strobe = 1'b0;
		// Sync ignored while disabled; down-only monitor
		monitorMode = MON_DOWN;
		host.wrReg(ADDR_MODE, 8'h03);
		waitCond(1, 200, n);
		check({secondOn, firstCode}, 8'h2f, "tx ignored");
		anaIn.monBelow = 1'b1;
		tick(10);
		check({7'h00, firstCode < 7'd47}, 8'h01, "lowered");
		anaIn.monBelow = 1'b0;
		anaIn.monAboveHyst = 1'b1;
		tick(4);
		rd = {1'b0, firstCode};
		tick(20);
		check({1'b0, firstCode}, rd, "no raise");
		waitCond(2, 200, n);
		host.rdReg(ADDR_FLAGS, rd);
		check(rd, 8'h09, "monitor flag");
		anaIn.monAboveHyst = 1'b0;
		pinsIn.tx = 1'b0;
		// Up-and-down monitor lowers, then raises again
		monitorMode = MON_UPDN;
		host.wrReg(ADDR_MODE, 8'h03);
		waitCond(1, 200, n);
		anaIn.monBelow = 1'b1;
		tick(10);
		rd = {1'b0, firstCode};
		check({7'h00, firstCode < 7'd47}, 8'h01, "up-down lowered");
		anaIn.monBelow = 1'b0;
		anaIn.monAboveHyst = 1'b1;
		tick(20);
		check({7'h00, {1'b0, firstCode} > rd}, 8'h01, "up-down raised");
		waitCond(2, 200, n);
		host.rdReg(ADDR_FLAGS, rd);
		check(rd, 8'h09, "up-down flags");
		anaIn.monAboveHyst = 1'b0;
		// Shortest timeout length
		host.wrReg(ADDR_TIMING, 8'h00);
		host.wrReg(ADDR_MODE, 8'h03);
		waitCond(3, 20, n);
		waitCond(2, 40, n);
		check({7'h00, n >= 19 && n <= 21}, 8'h01, "timeout length");
		host.rdReg(ADDR_FLAGS, rd);
		check(rd, 8'h01, "short timeout flag");
		// Stop-and-hold freezes the ramp part way up
		monitorMode = MON_HOLD;
		host.wrReg(ADDR_MODE, 8'h03);
		waitCond(3, 20, n);
		tick(4);
		anaIn.monBelow = 1'b1;
		tick(4);
		rd = {1'b0, firstCode};
		tick(8);
		check({1'b0, firstCode}, rd, "held level");
		anaIn.monBelow = 1'b0;
		waitCond(2, 40, n);
		host.rdReg(ADDR_FLAGS, rd);
		check(rd, 8'h09, "hold flags");
		// Reset after the last run returns the ceiling register to its reset value
		srst = 1'b1;
		tick(3);
		srst = 1'b0;
		host.rdReg(ADDR_CEIL, rd);
		check(rd, CEIL_RST, "ceiling after reset");
		completeRun();
	end
endmodule : led_flash_torch_control_bench
`default_nettype wire
